//--- include/kwu_pkg.sv
// Package of the key wake unit: register indices, field positions, reset values.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses of 8 bits.
package kwu_pkg;

  // --------------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // --------------------------------------------------------------------------
  localparam logic [5:0] IDX_WAKE_STATUS_CONTROL  = 6'h0c;
  localparam logic [5:0] IDX_WAKE_PIN_ENABLE      = 6'h0d;
  localparam logic [5:0] IDX_WAKE_POLARITY_SELECT = 6'h0e;
  localparam logic [5:0] IDX_PORT_A_PULL_ENABLE   = 6'h0f;
  localparam logic [5:0] IDX_EVENT_STATUS         = 6'h10;
  localparam logic [5:0] IDX_EVENT_MASK           = 6'h11;

  // --------------------------------------------------------------------------
  // Fields of the status and control register, and the number of inputs.
  // --------------------------------------------------------------------------
  localparam int BIT_SENSITIVITY_MODE  = 0;
  localparam int BIT_REQUEST_ENABLE    = 1;
  localparam int BIT_FLAG_ACKNOWLEDGE  = 2;
  localparam int BIT_DETECT_FLAG       = 3;
  localparam int NUM_INPUTS            = 4;

  // --------------------------------------------------------------------------
  // Reset values and bus answers.
  // --------------------------------------------------------------------------
  localparam logic [3:0] RST_FIELD4     = 4'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

//--- src/kwu_key_wake_unit.sv
// Key wake unit: four-input wake and interrupt detector behind an AXI4-Lite slave.
// Assumes port pins are asynchronous to aclk and the master follows AXI4-Lite.
`timescale 1ns/1ps

module kwu_key_wake_unit
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  port_a_pins,
  output logic [3:0]       pullup_enable,
  output logic [3:0]       pulldown_enable,
  output logic             wake_request,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == kwu_pkg::IDX_WAKE_STATUS_CONTROL)  ||
                (idx == kwu_pkg::IDX_WAKE_PIN_ENABLE)      ||
                (idx == kwu_pkg::IDX_WAKE_POLARITY_SELECT) ||
                (idx == kwu_pkg::IDX_PORT_A_PULL_ENABLE)   ||
                (idx == kwu_pkg::IDX_EVENT_STATUS)         ||
                (idx == kwu_pkg::IDX_EVENT_MASK);
  endfunction

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic [3:0]  armed_r;
  logic [3:0]  armed_nxt;
  logic        detect_flag_r;
  logic        detect_flag_nxt;
  logic        request_enable_r;
  logic        request_enable_nxt;
  logic        sensitivity_mode_r;
  logic        sensitivity_mode_nxt;
  logic [3:0]  pin_enable_r;
  logic [3:0]  pin_enable_nxt;
  logic [3:0]  polarity_r;
  logic [3:0]  polarity_nxt;
  logic [3:0]  pull_enable_r;
  logic [3:0]  pull_enable_nxt;
  logic [3:0]  event_status_r;
  logic [3:0]  event_status_nxt;
  logic [3:0]  event_mask_r;
  logic [3:0]  event_mask_nxt;
  logic [3:0]  pullup_r;
  logic [3:0]  pullup_nxt;
  logic [3:0]  pulldown_r;
  logic [3:0]  pulldown_nxt;

  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [5:0]  aw_idx_r;
  logic [5:0]  aw_idx_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic [3:0]  w_data_r;
  logic [3:0]  w_data_nxt;
  logic        w_lane0_r;
  logic        w_lane0_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;

  // --------------------------------------------------------------------------
  // Detection.
  // --------------------------------------------------------------------------
  logic [3:0]  asserted;
  logic [3:0]  edge_hit;
  logic [3:0]  level_hit;
  logic [3:0]  detect_hit;
  logic        do_write;
  logic        do_read;
  logic [5:0]  ar_idx;
  logic        ack_write;

  always_comb
  begin
    // Polarity 1 makes a high pin the asserted sense.
    asserted   = ~(sync2_r ^ polarity_r);
    // Armed means the input was seen at its reset level while enabled.
    armed_nxt  = pin_enable_r & (armed_r | ~asserted) & ~asserted;
    edge_hit   = pin_enable_r & armed_r & asserted;
    level_hit  = (sensitivity_mode_r ? pin_enable_r & asserted : 4'h0);
    detect_hit = edge_hit | level_hit;
  end

  // --------------------------------------------------------------------------
  // Bus slave and registers.
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign do_write      = aw_held_r && w_held_r;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[7:2];
  assign ack_write     = do_write && w_lane0_r &&
                         (aw_idx_r == kwu_pkg::IDX_WAKE_STATUS_CONTROL) &&
                         w_data_r[kwu_pkg::BIT_FLAG_ACKNOWLEDGE];

  always_comb
  begin
    aw_held_nxt          = aw_held_r;
    aw_idx_nxt           = aw_idx_r;
    w_held_nxt           = w_held_r;
    w_data_nxt           = w_data_r;
    w_lane0_nxt          = w_lane0_r;
    bvalid_nxt           = bvalid_r && !s_axi_bready;
    bresp_nxt            = bresp_r;
    rvalid_nxt           = rvalid_r && !s_axi_rready;
    rdata_nxt            = rdata_r;
    rresp_nxt            = rresp_r;
    request_enable_nxt   = request_enable_r;
    sensitivity_mode_nxt = sensitivity_mode_r;
    pin_enable_nxt       = pin_enable_r;
    polarity_nxt         = polarity_r;
    pull_enable_nxt      = pull_enable_r;
    event_mask_nxt       = event_mask_r;
    event_status_nxt     = event_status_r;
    detect_flag_nxt      = detect_flag_r;

    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata[3:0];
      w_lane0_nxt = s_axi_wstrb[0];
    end

    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = is_mapped(aw_idx_r) ? kwu_pkg::RESP_OKAY : kwu_pkg::RESP_SLVERR;
      if (w_lane0_r)
      begin
        unique case (aw_idx_r)
          kwu_pkg::IDX_WAKE_STATUS_CONTROL:
          begin
            // Upper bits, the flag and the acknowledge bit of the write data are not stored.
            request_enable_nxt   = w_data_r[kwu_pkg::BIT_REQUEST_ENABLE];
            sensitivity_mode_nxt = w_data_r[kwu_pkg::BIT_SENSITIVITY_MODE];
          end
          kwu_pkg::IDX_WAKE_PIN_ENABLE:      pin_enable_nxt  = w_data_r;
          kwu_pkg::IDX_WAKE_POLARITY_SELECT: polarity_nxt    = w_data_r;
          kwu_pkg::IDX_PORT_A_PULL_ENABLE:   pull_enable_nxt = w_data_r;
          kwu_pkg::IDX_EVENT_MASK:           event_mask_nxt  = w_data_r;
          default:
          begin
          end
        endcase
      end
    end

    if (do_read)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = is_mapped(ar_idx) ? kwu_pkg::RESP_OKAY : kwu_pkg::RESP_SLVERR;
      unique case (ar_idx)
        kwu_pkg::IDX_WAKE_STATUS_CONTROL:
          rdata_nxt[3:0] = {detect_flag_r, 1'b0, request_enable_r,
                            sensitivity_mode_r};
        kwu_pkg::IDX_WAKE_PIN_ENABLE:      rdata_nxt[3:0] = pin_enable_r;
        kwu_pkg::IDX_WAKE_POLARITY_SELECT: rdata_nxt[3:0] = polarity_r;
        kwu_pkg::IDX_PORT_A_PULL_ENABLE:   rdata_nxt[3:0] = pull_enable_r;
        kwu_pkg::IDX_EVENT_STATUS:
        begin
          rdata_nxt[3:0]   = event_status_r;
          event_status_nxt = 4'h0;
        end
        kwu_pkg::IDX_EVENT_MASK:           rdata_nxt[3:0] = event_mask_r;
        default:
        begin
        end
      endcase
    end

    // Sticky per-input events; a new hit in the read cycle is kept.
    event_status_nxt = event_status_nxt | detect_hit;

    // Level mode refuses the clear while any enabled input is asserted.
    if (ack_write && !(sensitivity_mode_r && |(pin_enable_r & asserted)))
      detect_flag_nxt = 1'b0;
    if (|detect_hit)
      detect_flag_nxt = 1'b1;

    // Pull direction follows polarity so the idle level is the reset level.
    pullup_nxt   = pull_enable_r & ~polarity_r;
    pulldown_nxt = pull_enable_r & polarity_r;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r            <= kwu_pkg::RST_FIELD4;
      sync2_r            <= kwu_pkg::RST_FIELD4;
      armed_r            <= kwu_pkg::RST_FIELD4;
      detect_flag_r      <= 1'b0;
      request_enable_r   <= 1'b0;
      sensitivity_mode_r <= 1'b0;
      pin_enable_r       <= kwu_pkg::RST_FIELD4;
      polarity_r         <= kwu_pkg::RST_FIELD4;
      pull_enable_r      <= kwu_pkg::RST_FIELD4;
      event_status_r     <= kwu_pkg::RST_FIELD4;
      event_mask_r       <= kwu_pkg::RST_FIELD4;
      pullup_r           <= kwu_pkg::RST_FIELD4;
      pulldown_r         <= kwu_pkg::RST_FIELD4;
      aw_held_r          <= 1'b0;
      aw_idx_r           <= 6'h00;
      w_held_r           <= 1'b0;
      w_data_r           <= kwu_pkg::RST_FIELD4;
      w_lane0_r          <= 1'b0;
      bvalid_r           <= 1'b0;
      bresp_r            <= kwu_pkg::RESP_OKAY;
      rvalid_r           <= 1'b0;
      rdata_r            <= 32'h0000_0000;
      rresp_r            <= kwu_pkg::RESP_OKAY;
    end
    else
    begin
      sync1_r            <= port_a_pins;
      sync2_r            <= sync1_r;
      armed_r            <= armed_nxt;
      detect_flag_r      <= detect_flag_nxt;
      request_enable_r   <= request_enable_nxt;
      sensitivity_mode_r <= sensitivity_mode_nxt;
      pin_enable_r       <= pin_enable_nxt;
      polarity_r         <= polarity_nxt;
      pull_enable_r      <= pull_enable_nxt;
      event_status_r     <= event_status_nxt;
      event_mask_r       <= event_mask_nxt;
      pullup_r           <= pullup_nxt;
      pulldown_r         <= pulldown_nxt;
      aw_held_r          <= aw_held_nxt;
      aw_idx_r           <= aw_idx_nxt;
      w_held_r           <= w_held_nxt;
      w_data_r           <= w_data_nxt;
      w_lane0_r          <= w_lane0_nxt;
      bvalid_r           <= bvalid_nxt;
      bresp_r            <= bresp_nxt;
      rvalid_r           <= rvalid_nxt;
      rdata_r            <= rdata_nxt;
      rresp_r            <= rresp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs. No debug-mode input exists, so nothing can halt the unit.
  // --------------------------------------------------------------------------
  assign s_axi_bvalid    = bvalid_r;
  assign s_axi_bresp     = bresp_r;
  assign s_axi_rvalid    = rvalid_r;
  assign s_axi_rdata     = rdata_r;
  assign s_axi_rresp     = rresp_r;
  assign pullup_enable   = pullup_r;
  assign pulldown_enable = pulldown_r;
  assign wake_request    = detect_flag_r & request_enable_r;
  assign irq             = |(event_status_r & event_mask_r);

endmodule

//--- test/kwu_chk_sva.sv
// Checker of the key wake unit, watching bus handshakes, pulls and the request.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module kwu_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  pullup_enable,
  input wire logic [3:0]  pulldown_enable,
  input wire logic        wake_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
    else $error("read data above the low nibble is not zero");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  // Both channels taken together are held one cycle, so the answer follows two edges later.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_pull_exclusive: assert property ((pullup_enable & pulldown_enable) == 4'h0)
    else $error("pullup and pulldown both on");
  // The request can only drop on a register write or a reset.
  a_request_drop: assert property ($fell(wake_request) |->
    $rose(s_axi_bvalid) || !$past(aresetn)) else $error("request dropped without a write");
endmodule
bind kwu_key_wake_unit kwu_chk kwu_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pullup_enable,
  .pulldown_enable, .wake_request);

//--- test/kwu_pin_partner.sv
// Model of the switches on the four port pins.
// Assumes the bench drives drive_en and drive_val just after a rising edge.
`timescale 1ns/1ps
module kwu_pin_partner
(
  input  wire logic       aclk,
  input  wire logic [3:0] drive_en,
  input  wire logic [3:0] drive_val,
  input  wire logic [3:0] pullup_enable,
  input  wire logic [3:0] pulldown_enable,
  output logic      [3:0] port_a_pins
);
  logic [3:0] last_r;
  always_ff @(posedge aclk)
    last_r <= port_a_pins;
  // A released pin with no resistor floats, so it toggles rather than keep its level.
  always_comb
    for (int i = 0; i < 4; i++)
      port_a_pins[i] = drive_en[i] ? drive_val[i] : pullup_enable[i] ? 1'b1 :
                       pulldown_enable[i] ? 1'b0 : ~last_r[i];
endmodule

//--- test/kwu_key_wake_unit_tb_top.sv
// Self-checking bench of the key wake unit over AXI4-Lite.
// Assumes the design package is compiled first and the checker is bound.
`timescale 1ns/1ps
module kwu_key_wake_unit_tb_top;
  localparam logic [7:0] SC  = {kwu_pkg::IDX_WAKE_STATUS_CONTROL, 2'h0};
  localparam logic [7:0] EN  = {kwu_pkg::IDX_WAKE_PIN_ENABLE, 2'h0};
  localparam logic [7:0] POL = {kwu_pkg::IDX_WAKE_POLARITY_SELECT, 2'h0};
  localparam logic [7:0] PUL = {kwu_pkg::IDX_PORT_A_PULL_ENABLE, 2'h0};
  localparam logic [7:0] EVS = {kwu_pkg::IDX_EVENT_STATUS, 2'h0};
  localparam logic [7:0] MSK = {kwu_pkg::IDX_EVENT_MASK, 2'h0};
  localparam logic [1:0] OK = kwu_pkg::RESP_OKAY, SE = kwu_pkg::RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  drv_en = 4'hf;
  logic [3:0]  drv_val = 4'h3;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0]  port_a_pins, pullup_enable, pulldown_enable;
  logic        wake_request, irq;
  int          err_count = 0;
  int          check_count = 0;
  kwu_key_wake_unit kwu_key_wake_unit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_a_pins, .pullup_enable, .pulldown_enable,
    .wake_request, .irq);
  kwu_pin_partner kwu_pin_partner_i (.aclk, .drive_en(drv_en), .drive_val(drv_val),
    .pullup_enable, .pulldown_enable, .port_a_pins);
  always #5 aclk = ~aclk;
  // ----
  // Bus and compare tasks.
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Ready is raised in the same cycle the answer appears, so the slave never has to hold it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!(aw && w));
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // ----
  // Scenarios.
  // ----
  task automatic t_regs();
    rd(SC, 32'h0, OK);
    rd(EN, 32'h0, OK);
    wr(POL, 32'hfa, OK);
    rd(POL, 32'h0a, OK);
    wr(POL, 32'h04, OK);
    wr(EN, 32'hff, OK);
    rd(EN, 32'h0f, OK);
    wr(EN, 32'h0, OK);
    // A write without the low byte lane must leave the register alone.
    s_axi_wstrb <= 4'he;
    wr(EN, 32'hff, OK);
    s_axi_wstrb <= 4'hf;
    rd(EN, 32'h0, OK);
    wr(SC, 32'hff, OK);
    rd(SC, 32'h03, OK);
    wr(8'h80, 32'h1, SE);
    rd(8'h80, 32'h0, SE);
    $display("register test done");
  endtask
  task automatic t_edge();
    wr(SC, 32'h00, OK);
    wr(EN, 32'h0d, OK);
    wr(SC, 32'h04, OK);
    wr(SC, 32'h02, OK);
    wr(MSK, 32'h01, OK);
    drv_val <= 4'h1;
    cyc(4);
    rd(SC, 32'h02, OK);
    drv_val <= 4'h0;
    cyc(4);
    chk(32'(wake_request), 32'h1);
    chk(32'(irq), 32'h1);
    rd(SC, 32'h0a, OK);
    rd(EVS, 32'h01, OK);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(SC, 32'h06, OK);
    rd(SC, 32'h02, OK);
    chk(32'(wake_request), 32'h0);
    drv_val <= 4'h4;
    cyc(4);
    rd(SC, 32'h0a, OK);
    chk(32'(irq), 32'h0);
    wr(SC, 32'h06, OK);
    $display("edge test done");
  endtask
  // The falling edge on input 0 reaches the detector in the very cycle the acknowledge lands.
  task automatic t_race();
    drv_val <= 4'h5;
    cyc(4);
    drv_val <= 4'h4;
    cyc(1);
    wr(SC, 32'h06, OK);
    rd(SC, 32'h0a, OK);
    wr(SC, 32'h06, OK);
    rd(SC, 32'h02, OK);
    $display("race test done");
  endtask
  task automatic t_level();
    wr(MSK, 32'h0, OK);
    wr(EN, 32'h01, OK);
    wr(SC, 32'h07, OK);
    cyc(2);
    wr(SC, 32'h07, OK);
    rd(SC, 32'h0b, OK);
    chk(32'(irq), 32'h0);
    drv_val <= 4'h5;
    cyc(4);
    wr(SC, 32'h07, OK);
    rd(SC, 32'h03, OK);
    $display("level test done");
  endtask
  task automatic t_pulls();
    wr(PUL, 32'h0f, OK);
    cyc(1);
    chk(32'(pullup_enable), 32'h0b);
    chk(32'(pulldown_enable), 32'h04);
    drv_en <= 4'h0;
    cyc(4);
    rd(SC, 32'h03, OK);
    rd(PUL, 32'h0f, OK);
    $display("pull test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_edge();
    t_race();
    t_level();
    t_pulls();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    give_verdict();
  end
endmodule
